// ### hdl/dmove_defs.svh
// constants for the data movement unit: bus map, fields, areas, limits
`ifndef DMOVE_DEFS_SVH
`define DMOVE_DEFS_SVH
`define DMV_AXI_AW 13
`define DMV_MEM_SEL_BIT 12
`define DMV_MEM_WORDS 1024
`define DMV_REG_CTRL 3'h0
`define DMV_REG_OPCODE 3'h1
`define DMV_REG_SRC 3'h2
`define DMV_REG_DST 3'h3
`define DMV_REG_END 3'h4
`define DMV_REG_COL 3'h5
`define DMV_REG_IMM 3'h6
`define DMV_REG_STATUS 3'h7
`define DMV_CTRL_COND_BIT 0
`define DMV_ADDR_MSB 9
`define DMV_IND_BIT 15
`define DMV_IMM_BIT 16
`define DMV_ST_BUSY_BIT 0
`define DMV_ST_ERR_BIT 1
`define DMV_ST_ZERO_BIT 2
`define DMV_ST_DONE_BIT 3
`define DMV_AREA_DM 3'h6
`define DMV_AREA_TC 3'h7
`define DMV_SET_LAST_OFS 7'h70
`define DMV_COL_MAX 14'h000F
`define DMV_PTR_MAX 14'h007F
`define DMV_SET_LAST_IDX 4'hF
`define DMV_RST_OPCODE 3'h0
`define DMV_RST_SRC 17'h00000
`define DMV_RST_ADDR 16'h0000
`define DMV_RST_WORD 16'h0000
`define DMV_RESP_OKAY 2'h0
`define DMV_RESP_DECERR 2'h3
`endif

// ### hdl/dmove_pkg.sv
// types shared by the data movement unit
`default_nettype none
package dmove_pkg;
	typedef enum logic [2:0] {
		OP_COPY = 3'h0,
		OP_INVERT = 3'h1,
		OP_GATHER = 3'h2,
		OP_SCATTER = 3'h3,
		OP_FILL = 3'h4
	} op_t;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_PTR = 4'h2,
		ST_CHECK = 4'h4,
		ST_RUN = 4'h8
	} eng_state_t;
endpackage : dmove_pkg
`default_nettype wire

// ### hdl/bcd_check.sv
// four-digit bcd validity check and conversion to binary
`default_nettype none
module bcd_check (
	input wire logic [15:0] bcd_in,
	output logic is_bcd,
	output logic [13:0] bin_out
);
	always_comb begin
		is_bcd = (bcd_in[15:12] <= 4'h9) && (bcd_in[11:8] <= 4'h9) &&
			(bcd_in[7:4] <= 4'h9) && (bcd_in[3:0] <= 4'h9);
		bin_out = 14'(bcd_in[15:12]) * 14'h03E8 + 14'(bcd_in[11:8]) * 14'h0064 +
			14'(bcd_in[7:4]) * 14'h000A + 14'(bcd_in[3:0]);
	end
endmodule : bcd_check
`default_nettype wire

// ### hdl/data_move_instruction_unit.sv
// data movement instruction unit with its own word memory, run over axi4-lite
//
// What this block does
// [RULE1] only destination words change; sources keep their contents
// [RULE2] word copy writes source to destination only while condition on
// [RULE3] inverted copy writes bitwise complement of source to destination
// [RULE4] inverted copy source is a memory word or immediate constant
// [RULE5] copy and inverted copy set zero flag when written value zero
// [RULE6] copy and inverted copy refuse timer/counter destination
// [RULE7] error flag when an indirect pointer is not bcd or outside area
// [RULE8] column gather packs bit C of sixteen source words into destination
// [RULE9] gather column selector is bcd 0 to 15
// [RULE10] gather raises error for non-bcd selector or bit beyond 15
// [RULE11] gather sets zero flag when the resulting word is zero
// [RULE12] column scatter writes source bits into bit C of sixteen words
// [RULE13] scatter column selector lies in range 00 to 15
// [RULE14] block fill writes source into every word start through end
// [RULE15] fill errors when areas differ or start exceeds end
// [RULE16] fill may write timer/counter words
// [RULE17] an operation flagging an error writes no destination word
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`include "dmove_defs.svh"
`default_nettype none
module data_move_instruction_unit (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [12:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [12:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic error_flag,
	output logic zero_flag,
	output logic busy
);
	logic [15:0] mem [0:`DMV_MEM_WORDS-1];

	logic aw_held_r, w_held_r, ar_held_r;
	logic awready_r, wready_r, arready_r, bvalid_r, rvalid_r;
	logic [12:0] awaddr_r, araddr_r;
	logic [31:0] wdata_r, rdata_r;
	logic [3:0] wstrb_r;
	logic [1:0] bresp_r, rresp_r;

	logic [2:0] opcode_r;
	logic [16:0] src_r;
	logic [15:0] dst_r, end_r, col_r, imm_r;
	logic error_r, zero_r, done_r, busy_r;

	dmove_pkg::eng_state_t state_r;
	logic [1:0] ptr_idx_r;
	logic [9:0] eff_src_r, eff_dst_r, eff_end_r, cur_r;
	logic [3:0] idx_r;
	logic [15:0] val_r, acc_r;

	logic idle, aw_mem, aw_unmapped, ar_mem, ar_unmapped;
	logic wr_fire, rd_fire, reg_wr, mem_wr, go;
	logic [31:0] rd_mux;
	logic [9:0] eng_ra;
	logic [15:0] eng_rd;
	logic ptr_bcd_ok, col_bcd_ok, ptr_ok, col_ok, need_ind, check_err;
	logic [13:0] ptr_bin, col_bin;
	logic [3:0] col_sel;
	logic [9:0] ptr_addr;
	logic eng_we, eng_fin, eng_abort;
	logic [9:0] eng_wa;
	logic [15:0] eng_wd;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge_bytes

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign error_flag = error_r;
	assign zero_flag = zero_r;
	assign busy = busy_r;

	// memory window is held off while an instruction runs
	assign idle = (state_r == dmove_pkg::ST_IDLE);
	assign aw_mem = awaddr_r[`DMV_MEM_SEL_BIT];
	assign aw_unmapped = !aw_mem && (awaddr_r[11:5] != 7'h00);
	assign ar_mem = araddr_r[`DMV_MEM_SEL_BIT];
	assign ar_unmapped = !ar_mem && (araddr_r[11:5] != 7'h00);
	assign wr_fire = aw_held_r && w_held_r && !bvalid_r && (!aw_mem || idle);
	assign rd_fire = ar_held_r && !rvalid_r && (!ar_mem || idle);
	assign reg_wr = wr_fire && !aw_mem && !aw_unmapped;
	assign mem_wr = wr_fire && aw_mem;
	// [RULE2] condition off means nothing runs
	assign go = reg_wr && (awaddr_r[4:2] == `DMV_REG_CTRL) && wstrb_r[0] &&
		wdata_r[`DMV_CTRL_COND_BIT] && idle;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			aw_held_r <= 1'b0;
			awready_r <= 1'b0;
			awaddr_r <= 13'h0000;
		end else if (s_axi_awvalid && awready_r) begin
			awaddr_r <= s_axi_awaddr;
			aw_held_r <= 1'b1;
			awready_r <= 1'b0;
		end else if (wr_fire) begin
			aw_held_r <= 1'b0;
		end else if (!aw_held_r && !bvalid_r) begin
			awready_r <= 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			w_held_r <= 1'b0;
			wready_r <= 1'b0;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
		end else if (s_axi_wvalid && wready_r) begin
			wdata_r <= s_axi_wdata;
			wstrb_r <= s_axi_wstrb;
			w_held_r <= 1'b1;
			wready_r <= 1'b0;
		end else if (wr_fire) begin
			w_held_r <= 1'b0;
		end else if (!w_held_r && !bvalid_r) begin
			wready_r <= 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			bvalid_r <= 1'b0;
			bresp_r <= `DMV_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_r <= 1'b1;
			bresp_r <= aw_unmapped ? `DMV_RESP_DECERR : `DMV_RESP_OKAY;
		end else if (bvalid_r && s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ar_held_r <= 1'b0;
			arready_r <= 1'b0;
			araddr_r <= 13'h0000;
		end else if (s_axi_arvalid && arready_r) begin
			araddr_r <= s_axi_araddr;
			ar_held_r <= 1'b1;
			arready_r <= 1'b0;
		end else if (rd_fire) begin
			ar_held_r <= 1'b0;
		end else if (!ar_held_r && !rvalid_r) begin
			arready_r <= 1'b1;
		end
	end

	always_comb begin
		rd_mux = 32'h00000000;
		if (ar_mem) begin
			rd_mux = {16'h0000, mem[araddr_r[11:2]]};
		end else if (!ar_unmapped) begin
			case (araddr_r[4:2])
				`DMV_REG_OPCODE: rd_mux = {29'h00000000, opcode_r};
				`DMV_REG_SRC: rd_mux = {15'h0000, src_r};
				`DMV_REG_DST: rd_mux = {16'h0000, dst_r};
				`DMV_REG_END: rd_mux = {16'h0000, end_r};
				`DMV_REG_COL: rd_mux = {16'h0000, col_r};
				`DMV_REG_IMM: rd_mux = {16'h0000, imm_r};
				`DMV_REG_STATUS: begin
					rd_mux[`DMV_ST_BUSY_BIT] = !idle;
					rd_mux[`DMV_ST_ERR_BIT] = error_r;
					rd_mux[`DMV_ST_ZERO_BIT] = zero_r;
					rd_mux[`DMV_ST_DONE_BIT] = done_r;
				end
				default: rd_mux = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= `DMV_RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_mux;
			rresp_r <= ar_unmapped ? `DMV_RESP_DECERR : `DMV_RESP_OKAY;
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// operand registers, writes ignored while busy
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			opcode_r <= `DMV_RST_OPCODE;
			src_r <= `DMV_RST_SRC;
			dst_r <= `DMV_RST_ADDR;
			end_r <= `DMV_RST_ADDR;
			col_r <= `DMV_RST_WORD;
			imm_r <= `DMV_RST_WORD;
		end else if (reg_wr && idle) begin
			case (awaddr_r[4:2])
				`DMV_REG_OPCODE: opcode_r <= 3'(merge_bytes({29'h0, opcode_r}, wdata_r, wstrb_r));
				`DMV_REG_SRC: src_r <= 17'(merge_bytes({15'h0, src_r}, wdata_r, wstrb_r));
				`DMV_REG_DST: dst_r <= 16'(merge_bytes({16'h0, dst_r}, wdata_r, wstrb_r));
				`DMV_REG_END: end_r <= 16'(merge_bytes({16'h0, end_r}, wdata_r, wstrb_r));
				`DMV_REG_COL: col_r <= 16'(merge_bytes({16'h0, col_r}, wdata_r, wstrb_r));
				`DMV_REG_IMM: imm_r <= 16'(merge_bytes({16'h0, imm_r}, wdata_r, wstrb_r));
				default: ;
			endcase
		end
	end

	bcd_check u_ptr_bcd (
		.bcd_in(eng_rd),
		.is_bcd(ptr_bcd_ok),
		.bin_out(ptr_bin)
	);

	bcd_check u_col_bcd (
		.bcd_in(col_r),
		.is_bcd(col_bcd_ok),
		.bin_out(col_bin)
	);

	// [RULE7] pointer must be bcd and inside the area
	assign ptr_ok = ptr_bcd_ok && (ptr_bin <= `DMV_PTR_MAX);
	// [RULE9] [RULE13] selector bcd and at most 15
	assign col_ok = col_bcd_ok && (col_bin <= `DMV_COL_MAX);
	assign col_sel = col_bin[3:0];
	assign ptr_addr = {`DMV_AREA_DM, ptr_bin[6:0]};
	assign eng_rd = mem[eng_ra];

	always_comb begin
		eng_ra = eff_src_r;
		need_ind = 1'b0;
		case (state_r)
			dmove_pkg::ST_PTR: begin
				case (ptr_idx_r)
					2'h0: begin
						eng_ra = {`DMV_AREA_DM, src_r[6:0]};
						need_ind = src_r[`DMV_IND_BIT] && !src_r[`DMV_IMM_BIT];
					end
					2'h1: begin
						eng_ra = {`DMV_AREA_DM, dst_r[6:0]};
						need_ind = dst_r[`DMV_IND_BIT];
					end
					default: begin
						eng_ra = {`DMV_AREA_DM, end_r[6:0]};
						need_ind = end_r[`DMV_IND_BIT] && (opcode_r == dmove_pkg::OP_FILL);
					end
				endcase
			end
			dmove_pkg::ST_RUN: begin
				if (opcode_r == dmove_pkg::OP_GATHER) begin
					eng_ra = eff_src_r + 10'(idx_r);
				end else if (opcode_r == dmove_pkg::OP_SCATTER) begin
					eng_ra = eff_dst_r + 10'(idx_r);
				end
			end
			default: eng_ra = eff_src_r;
		endcase
	end

	always_comb begin
		check_err = 1'b0;
		case (opcode_r)
			// [RULE6] copies refuse the timer/counter area
			dmove_pkg::OP_COPY, dmove_pkg::OP_INVERT: check_err = (eff_dst_r[9:7] == `DMV_AREA_TC);
			// [RULE10] bad gather selector or set past area end
			dmove_pkg::OP_GATHER: check_err = !col_ok || (eff_src_r[6:0] > `DMV_SET_LAST_OFS);
			dmove_pkg::OP_SCATTER: check_err = !col_ok || (eff_dst_r[6:0] > `DMV_SET_LAST_OFS);
			// [RULE15] [RULE16] same area, start not past end, any area
			dmove_pkg::OP_FILL: check_err = (eff_dst_r[9:7] != eff_end_r[9:7]) || (eff_dst_r > eff_end_r);
			default: check_err = 1'b1;
		endcase
	end

	always_comb begin
		eng_we = 1'b0;
		eng_wa = eff_dst_r;
		eng_wd = val_r;
		eng_fin = 1'b0;
		if (state_r == dmove_pkg::ST_RUN) begin
			case (opcode_r)
				// [RULE2] plain copy
				dmove_pkg::OP_COPY: begin
					eng_we = 1'b1;
					eng_fin = 1'b1;
				end
				// [RULE3] complement of source
				dmove_pkg::OP_INVERT: begin
					eng_we = 1'b1;
					eng_wd = ~val_r;
					eng_fin = 1'b1;
				end
				// [RULE8] collect bit C of each word
				dmove_pkg::OP_GATHER: begin
					eng_wd = acc_r;
					eng_wd[idx_r] = eng_rd[col_sel];
					eng_fin = (idx_r == `DMV_SET_LAST_IDX);
					eng_we = eng_fin;
				end
				// [RULE12] only bit C of each word changes
				dmove_pkg::OP_SCATTER: begin
					eng_wa = eng_ra;
					eng_wd = eng_rd;
					eng_wd[col_sel] = val_r[idx_r];
					eng_we = 1'b1;
					eng_fin = (idx_r == `DMV_SET_LAST_IDX);
				end
				// [RULE14] fill start through end
				dmove_pkg::OP_FILL: begin
					eng_wa = cur_r;
					eng_we = 1'b1;
					eng_fin = (cur_r == eff_end_r);
				end
				default: eng_fin = 1'b1;
			endcase
		end
	end

	// [RULE17] aborts happen before any destination write
	assign eng_abort = ((state_r == dmove_pkg::ST_PTR) && need_ind && !ptr_ok) ||
		((state_r == dmove_pkg::ST_CHECK) && check_err);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_r <= dmove_pkg::ST_IDLE;
			ptr_idx_r <= 2'h0;
			eff_src_r <= 10'h000;
			eff_dst_r <= 10'h000;
			eff_end_r <= 10'h000;
			cur_r <= 10'h000;
			idx_r <= 4'h0;
			val_r <= `DMV_RST_WORD;
			acc_r <= `DMV_RST_WORD;
		end else begin
			case (state_r)
				dmove_pkg::ST_IDLE: begin
					if (go) begin
						state_r <= dmove_pkg::ST_PTR;
						ptr_idx_r <= 2'h0;
						eff_src_r <= src_r[`DMV_ADDR_MSB:0];
						eff_dst_r <= dst_r[`DMV_ADDR_MSB:0];
						eff_end_r <= end_r[`DMV_ADDR_MSB:0];
					end
				end
				dmove_pkg::ST_PTR: begin
					if (eng_abort) begin
						state_r <= dmove_pkg::ST_IDLE;
					end else begin
						if (need_ind) begin
							case (ptr_idx_r)
								2'h0: eff_src_r <= ptr_addr;
								2'h1: eff_dst_r <= ptr_addr;
								default: eff_end_r <= ptr_addr;
							endcase
						end
						ptr_idx_r <= ptr_idx_r + 2'h1;
						if (ptr_idx_r == 2'h2) begin
							state_r <= dmove_pkg::ST_CHECK;
						end
					end
				end
				dmove_pkg::ST_CHECK: begin
					if (eng_abort) begin
						state_r <= dmove_pkg::ST_IDLE;
					end else begin
						state_r <= dmove_pkg::ST_RUN;
						// [RULE4] [RULE1] source taken once, never written back
						val_r <= src_r[`DMV_IMM_BIT] ? imm_r : eng_rd;
						idx_r <= 4'h0;
						acc_r <= `DMV_RST_WORD;
						cur_r <= eff_dst_r;
					end
				end
				dmove_pkg::ST_RUN: begin
					acc_r <= eng_wd;
					idx_r <= idx_r + 4'h1;
					cur_r <= cur_r + 10'h001;
					if (eng_fin) begin
						state_r <= dmove_pkg::ST_IDLE;
					end
				end
				default: state_r <= dmove_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			error_r <= 1'b0;
			zero_r <= 1'b0;
			done_r <= 1'b0;
		end else if (go) begin
			error_r <= 1'b0;
			done_r <= 1'b0;
		end else if (eng_abort) begin
			error_r <= 1'b1;
			done_r <= 1'b1;
		end else if (eng_fin) begin
			done_r <= 1'b1;
			// [RULE5] [RULE11] zero flag from the written word
			if (opcode_r == dmove_pkg::OP_COPY || opcode_r == dmove_pkg::OP_INVERT ||
				opcode_r == dmove_pkg::OP_GATHER) begin
				zero_r <= (eng_wd == 16'h0000);
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			busy_r <= 1'b0;
		end else if (go) begin
			busy_r <= 1'b1;
		end else if (eng_abort || eng_fin) begin
			busy_r <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (eng_we) begin
			mem[eng_wa] <= eng_wd;
		end else if (mem_wr) begin
			mem[awaddr_r[11:2]] <= 16'(merge_bytes({16'h0000, mem[awaddr_r[11:2]]}, wdata_r, wstrb_r));
		end
	end
endmodule : data_move_instruction_unit
`default_nettype wire

// ### tb/dmove_unit_asserts.sv
// bus and run-timing checker for the data movement unit
`default_nettype none
module dmove_unit_asserts (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [12:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [12:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic error_flag,
	input wire logic zero_flag,
	input wire logic busy
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	sequence s_go;
		$rose(busy);
	endsequence
	sequence s_ar_reg;
		s_axi_arvalid && s_axi_arready && !s_axi_araddr[12];
	endsequence
	a_busy_min_len: assert property ($fell(busy) && !error_flag |-> $past(busy, 5))
		else $error("clean run shorter than its phases");
	a_busy_ends: assert property (s_go |-> ##[1:200] !busy)
		else $error("run does not finish");
	a_err_cleared: assert property (s_go |-> ##[0:1] !error_flag)
		else $error("error flag not cleared by go");
	a_flags_hold_idle: assert property (!busy && !$past(busy) |-> $stable(error_flag) && $stable(zero_flag))
		else $error("flag moved while idle");
	a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_reg_rd_answer: assert property (s_ar_reg |-> ##2 s_axi_rvalid)
		else $error("register read late");
	a_decerr_read: assert property ((s_ar_reg and (s_axi_araddr[11:5] != 7'h00)) |-> ##2 (s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0))
		else $error("unmapped read not refused");
	a_ready_gap: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_awready && !s_axi_wready)
		else $error("write ready without gap");
endmodule : dmove_unit_asserts
bind data_move_instruction_unit dmove_unit_asserts dmove_unit_asserts_i (.*);
`default_nettype wire

// ### tb/test_data_move_instruction_unit.sv
// self-checking bench for the data movement unit
`default_nettype none
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin error_cnt++; $display("ERROR %s exp %0h got %0h", nm, e, s); end end
module test_data_move_instruction_unit;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [12:0] s_axi_awaddr = 13'h0000, s_axi_araddr = 13'h0000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, error_flag, zero_flag, busy;
	logic [1:0] s_axi_bresp, s_axi_rresp, lr;
	int mdl[1024];
	int error_cnt = 0, checked = 0, cyc = 0, n;
	bit err_m = 0, zero_m = 0;
	logic [31:0] r;
	data_move_instruction_unit data_move_instruction_unit_i (.*);
	always #20 mclk = ~mclk;
	task automatic wrap_up;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			error_cnt++;
			wrap_up();
		end
	end
	task automatic wr(input logic [12:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		forever begin
			@(posedge mclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) begin
				lr = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
			s_axi_bready <= s_axi_bvalid;
		end
	endtask : wr
	task automatic rd(input logic [12:0] a, output logic [31:0] d);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		forever begin
			@(posedge mclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) begin
				d = s_axi_rdata;
				lr = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
			s_axi_rready <= s_axi_rvalid;
		end
	endtask : rd
	function automatic bit bcd_ok(int v);
		return v[3:0] < 10 && v[7:4] < 10 && v[11:8] < 10 && v[15:12] < 10 && v[31:16] == 0;
	endfunction : bcd_ok
	function automatic int bcd_val(int v);
		return v[3:0] + 10 * v[7:4] + 100 * v[11:8] + 1000 * v[15:12];
	endfunction : bcd_val
	// indirect operand goes through a data-memory pointer word
	function automatic int res(int a, inout bit e);
		int p;
		if (!a[15]) return a & 'h3FF;
		p = mdl['h300 + (a & 'h7F)];
		if (!bcd_ok(p) || bcd_val(p) > 127) e = 1;
		return 'h300 + (bcd_val(p) & 'h7F);
	endfunction : res
	task automatic ex(input int op, s, d, e, c, im, input bit go);
		int sa, da, ea, v, i, k;
		bit er;
		er = 0;
		sa = 0;
		ea = 0;
		if (!s[16]) sa = res(s, er);
		da = res(d, er);
		if (op == 4) ea = res(e, er);
		v = s[16] ? im : mdl[sa];
		k = bcd_val(c);
		if (op inside {2, 3} && (!bcd_ok(c) || k > 15 || ((op == 2 ? sa : da) & 'h7F) > 112)) er = 1;
		if (op < 2 && da[9:7] == 7 || op == 4 && (da[9:7] != ea[9:7] || da > ea) || op > 4) er = 1;
		if (go && !er) begin
			if (op == 1) v = ~v & 'hFFFF;
			if (op == 2) v = 0;
			for (i = 0; i < 16; i++) begin
				if (op == 2) v[i] = mdl[sa + i][k];
				if (op == 3) mdl[da + i][k] = v[i];
			end
			if (op <= 2) mdl[da] = v;
			if (op <= 2) zero_m = v == 0;
			if (op == 4) for (i = da; i <= ea; i++) mdl[i] = v;
		end
		if (go) err_m = er;
		wr(13'h0004, op);
		wr(13'h0008, s);
		wr(13'h000C, d);
		wr(13'h0010, e);
		wr(13'h0014, c);
		wr(13'h0018, im);
		wr(13'h0000, {31'h0, go});
		do rd(13'h001C, r); while (r[0] !== 1'b0);
		`CHK("busy", 1'b0, busy)
		`CHK("error_flag", err_m, error_flag)
		`CHK("zero_flag", zero_m, zero_flag)
		for (i = 'h300; i < 'h400; i++) begin
			rd(13'(4096 + 4 * i), r);
			`CHK("word", mdl[i], r)
		end
	endtask : ex
	initial begin
		void'($urandom(97062));
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		for (n = 'h300; n < 'h400; n++) begin
			mdl[n] = $urandom & 'hFFFF;
			if (n == 'h305) mdl[n] = 'h0042;
			if (n == 'h306) mdl[n] = 'h00A5;
			if (n == 'h307) mdl[n] = 'h0128;
			wr(13'(4096 + 4 * n), mdl[n]);
		end
		ex(0, 'h8005, 'h30C, 0, 0, 0, 1);
		ex(0, 'h8006, 'h30C, 0, 0, 0, 1);
		ex(0, 'h8007, 'h30D, 0, 0, 0, 1);
		ex(0, 'h300, 'h301, 0, 0, 0, 1);
		ex(0, 'h302, 'h303, 0, 0, 0, 0);
		ex(4, 'h10000, 'h3F0, 'h3F3, 0, 0, 1);
		ex(0, 'h3F1, 'h304, 0, 0, 0, 1);
		ex(1, 'h10000, 'h308, 0, 0, 'h5AC3, 1);
		ex(1, 'h309, 'h30A, 0, 0, 0, 1);
		ex(1, 'h10000, 'h30B, 0, 0, 'hFFFF, 1);
		ex(0, 'h300, 'h385, 0, 0, 0, 1);
		ex(2, 'h310, 'h330, 0, 'h0007, 0, 1);
		ex(2, 'h370, 'h331, 0, 'h0015, 0, 1);
		ex(2, 'h310, 'h331, 0, 'h0016, 0, 1);
		ex(2, 'h310, 'h331, 0, 'h000A, 0, 1);
		ex(2, 'h371, 'h332, 0, 'h0001, 0, 1);
		ex(4, 'h10000, 'h360, 'h36F, 0, 0, 1);
		ex(2, 'h360, 'h333, 0, 'h0003, 0, 1);
		ex(3, 'h300, 'h340, 0, 'h0000, 0, 1);
		ex(3, 'h301, 'h350, 0, 'h0015, 0, 1);
		ex(3, 'h301, 'h350, 0, 'h0016, 0, 1);
		ex(4, 'h300, 'h320, 'h32F, 0, 0, 1);
		ex(4, 'h300, 'h32F, 'h320, 0, 0, 1);
		ex(4, 'h300, 'h37E, 'h381, 0, 0, 1);
		ex(5, 'h300, 'h301, 0, 0, 0, 1);
		ex(0, 'h300, 'h8005, 0, 0, 0, 1);
		ex(4, 'h10000, 'h8005, 'h8005, 0, 'h1234, 1);
		ex(4, 'h10000, 'h8005, 'h8007, 0, 'h1234, 1);
		for (n = 0; n < 6; n++)
			ex($urandom % 5, 'h300 + $urandom % 128, 'h300 + $urandom % 256, 'h300 + $urandom % 256, $urandom % 'h1A, $urandom & 'hFFFF, 1);
		wr(13'h0020, 32'h1);
		`CHK("bresp", 2'h3, lr)
		rd(13'h0040, r);
		`CHK("rdata", 32'h0, r)
		`CHK("rresp", 2'h3, lr)
		wrap_up();
	end
endmodule : test_data_move_instruction_unit
`default_nettype wire
